/* core/iwr_defines.svh */
`ifndef IWR_DEFINES_SVH
`define IWR_DEFINES_SVH
// ----------------------------------------------------------------
// Command codes and lengths
// ----------------------------------------------------------------
`define IWR_CMD_PROTO      8'h02
`define IWR_CMD_IDLE       8'h07
`define IWR_CMD_READ       8'h08
`define IWR_CMD_WRITE      8'h09
`define IWR_LEN_IDLE       8'h0E
`define IWR_LEN_READ       8'h03
`define IWR_LEN_WR_IDX     8'h03
`define IWR_LEN_WR_VAL     8'h04
`define IWR_LEN_HDR        8'h02
// ----------------------------------------------------------------
// Register addresses and values
// ----------------------------------------------------------------
`define IWR_ADDR_WAKE      8'h62
`define IWR_ADDR_ACC       8'h69
`define IWR_ADDR_IDX       8'h68
`define IWR_IDX_ACC        8'h04
`define IWR_ACC_DEFAULT    8'h27
`define IWR_ACC_WR_MASK    8'h3F
`define IWR_RES_OK         8'h00
`define IWR_ERR_LEN        8'h82
`define IWR_LEN_ZERO       8'h00
`define IWR_LEN_ONE        8'h01
`define IWR_CAUSE_FIELD    8'h04
`define IWR_CAUSE_PIN      8'h08
`define IWR_WSRC_FIELD     1
`define IWR_WSRC_FIELD_ALT 2
`define IWR_WSRC_PIN       3
`define IWR_ENTRY_HIB      16'h0400
`define IWR_ENTRY_SLEEP    16'h0142
`define IWR_WAKE_HIB       16'h0400
`define IWR_WAKE_SLEEP     16'h3800
`define IWR_EXIT_CTRL      16'h1800
// ----------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------
`define IWR_BUF_DEPTH      16
`define IWR_CLK_MHZ        100
`define IWR_STARTUP_US     6000
`define IWR_STARTUP_CYC    (`IWR_STARTUP_US * `IWR_CLK_MHZ)
`define IWR_HALF_PER       4'h8
`define IWR_WAKE_LOW       8'h20
`endif

/* core/iwr_pkg.sv */
package iwr_pkg;
	// Device command states
	typedef enum logic [2:0] {
		DEV_POWERUP, DEV_STARTUP, DEV_READY, DEV_RESP, DEV_WFE
	} iwr_dev_state_t;
	// Host transfer states
	typedef enum logic [2:0] {
		HST_IDLE, HST_SEND, HST_WAIT, HST_READ, HST_DONE
	} iwr_host_state_t;
endpackage

/* core/iwr_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface iwr_link_if;
	logic sclk;        // Serial clock, host made, idle low
	logic cs_n;        // Frame select, active low
	logic mosi;        // Host to device data
	logic miso;        // Device to host data
	logic wake_n;      // Wake pulse, active low
	logic resp_rdy_n;  // Response pending, active low
	modport device (input sclk, cs_n, mosi, wake_n,
		output miso, resp_rdy_n);
	modport host (output sclk, cs_n, mosi, wake_n,
		input miso, resp_rdy_n);
endinterface
`default_nettype wire

/* core/iwr_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iwr_defines.svh"
module iwr_device #(
	parameter int STARTUP_CYCLES = `IWR_STARTUP_CYC
) (
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	iwr_link_if.device             link,
	input  wire logic              field_detect_in,
	output logic                   low_power_out,
	output logic                   cmd_ready_out,
	output logic [7:0]             analog_config_out,
	output logic [7:0]             wake_source_out
);
	import iwr_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	iwr_dev_state_t state_ff, nxt_state;     // Command state
	logic [19:0]    cnt_ff, nxt_cnt;         // Startup delay count
	logic [2:0]     sclk_s_ff, nxt_sclk_s;   // Sync plus edge history
	logic [2:0]     cs_s_ff, nxt_cs_s;
	logic [2:0]     wake_s_ff, nxt_wake_s;
	logic [2:0]     field_s_ff, nxt_field_s;
	logic [1:0]     mosi_s_ff, nxt_mosi_s;   // Data sync only
	logic [7:0]     rx_ff, nxt_rx;           // Receive shifter
	logic [7:0]     tx_ff, nxt_tx;           // Transmit shifter
	logic [2:0]     bit_ff, nxt_bit;         // Bits in current byte
	logic [4:0]     byte_ff, nxt_byte;       // Whole bytes in frame
	logic [1:0]     tx_idx_ff, nxt_tx_idx;   // Next answer byte
	logic [7:0]     cmd_ff [`IWR_BUF_DEPTH]; // Command bytes
	logic [7:0]     nxt_cmd [`IWR_BUF_DEPTH];
	logic [7:0]     resp_ff [3];             // Code, length, data
	logic [7:0]     nxt_resp [3];
	logic [7:0]     wsrc_ff, nxt_wsrc;       // Wake source enables
	logic [7:0]     acc_ff, nxt_acc;         // Analog config
	logic [7:0]     idx_ff, nxt_idx;         // Register index
	logic           hib_ff, nxt_hib;         // Hibernate selected
	logic           miso_ff, nxt_miso;
	logic           rdy_n_ff, nxt_rdy_n;
	logic           lp_ff, nxt_lp;
	logic           ready_ff, nxt_ready;

	// Edge decode, only from second and third stages
	function automatic logic rise(input logic [2:0] s);
		return s[1] & ~s[2];
	endfunction
	function automatic logic fall(input logic [2:0] s);
		return ~s[1] & s[2];
	endfunction
	function automatic logic [7:0] resp_byte(input logic [1:0] i,
		input logic [7:0] r0, input logic [7:0] r1,
		input logic [7:0] r2);
		case (i)
			2'h0:    return r0;
			2'h1:    return r1;
			2'h2:    return r2;
			default: return 8'h00;
		endcase
	endfunction

	logic       sclk_r, sclk_f, cs_r, cs_f, wake_f, field_r;
	logic       len_ok;
	logic [7:0] rbyte;
	logic [7:0] nbyte;
	assign sclk_r  = rise(sclk_s_ff);
	assign sclk_f  = fall(sclk_s_ff);
	assign cs_r    = rise(cs_s_ff);
	assign cs_f    = fall(cs_s_ff);
	assign wake_f  = fall(wake_s_ff);
	assign field_r = rise(field_s_ff);
	assign rbyte   = {rx_ff[6:0], mosi_s_ff[1]};
	// Whole frame must match its own length byte
	assign len_ok  = ({3'h0, byte_ff} == cmd_ff[1] + `IWR_LEN_HDR);
	assign nbyte   = resp_byte(tx_idx_ff, resp_ff[0], resp_ff[1],
		resp_ff[2]);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_sclk_s  = {sclk_s_ff[1:0], link.sclk};
		nxt_cs_s    = {cs_s_ff[1:0], link.cs_n};
		nxt_wake_s  = {wake_s_ff[1:0], link.wake_n};
		nxt_field_s = {field_s_ff[1:0], field_detect_in};
		nxt_mosi_s  = {mosi_s_ff[0], link.mosi};
		nxt_rx      = rx_ff;
		nxt_tx      = tx_ff;
		nxt_bit     = bit_ff;
		nxt_byte    = byte_ff;
		nxt_tx_idx  = tx_idx_ff;
		nxt_cmd     = cmd_ff;
		nxt_resp    = resp_ff;
		nxt_wsrc    = wsrc_ff;
		nxt_acc     = acc_ff;
		nxt_idx     = idx_ff;
		nxt_hib     = hib_ff;
		nxt_miso    = miso_ff;
		nxt_rdy_n   = rdy_n_ff;
		// Bit and byte counting on every rising serial edge while selected
		if (!cs_s_ff[1] && sclk_r) begin
			nxt_rx  = rbyte;
			nxt_bit = bit_ff + 3'h1;
			if (bit_ff == 3'h7 && byte_ff != 5'h1F) begin
				nxt_byte = byte_ff + 5'h1;
			end
			// Only a ready device takes command bytes
			if (bit_ff == 3'h7 && state_ff == DEV_READY &&
				!byte_ff[4]) begin
				nxt_cmd[byte_ff[3:0]] = rbyte;
			end
		end
		if (cs_f) begin
			nxt_bit  = 3'h0;
			nxt_byte = 5'h0;
		end
		case (state_ff)
			DEV_POWERUP: begin
				if (wake_f) begin
					nxt_state = DEV_STARTUP;
					nxt_cnt   = 20'h0;
				end
			end
			DEV_STARTUP: begin
				// Frames during startup are dropped
				nxt_cnt = cnt_ff + 20'h1;
				if (cnt_ff == 20'(STARTUP_CYCLES - 1)) begin
					nxt_state = DEV_READY;
				end
			end
			DEV_READY: begin
				if (cs_r && byte_ff != 5'h0) begin
					// Default answer: bad length or unknown
					nxt_resp[0] = `IWR_ERR_LEN;
					nxt_resp[1] = `IWR_LEN_ZERO;
					nxt_resp[2] = 8'h00;
					nxt_state   = DEV_RESP;
					nxt_rdy_n   = 1'b0;
					case (cmd_ff[0])
						`IWR_CMD_IDLE: begin
							if (len_ok && cmd_ff[1] == `IWR_LEN_IDLE) begin
								nxt_wsrc  = cmd_ff[2];
								nxt_hib   = {cmd_ff[3], cmd_ff[4]}
									== `IWR_ENTRY_HIB;
								nxt_state = DEV_WFE;
								nxt_rdy_n = 1'b1;
							end
						end
						`IWR_CMD_READ: begin
							// Only the two documented addresses answer
							if (len_ok && cmd_ff[1] == `IWR_LEN_READ &&
								(cmd_ff[2] == `IWR_ADDR_WAKE ||
								cmd_ff[2] == `IWR_ADDR_ACC)) begin
								nxt_resp[0] = `IWR_RES_OK;
								nxt_resp[1] = `IWR_LEN_ONE;
								if (cmd_ff[2] == `IWR_ADDR_WAKE) begin
									nxt_resp[2] = wsrc_ff;
								end else if (idx_ff == `IWR_IDX_ACC) begin
									nxt_resp[2] = acc_ff;
								end else begin
									// Unknown index reads as zero
									nxt_resp[2] = 8'h00;
								end
							end
						end
						`IWR_CMD_WRITE: begin
							if (len_ok && cmd_ff[2] == `IWR_ADDR_IDX &&
								(cmd_ff[1] == `IWR_LEN_WR_IDX ||
								cmd_ff[1] == `IWR_LEN_WR_VAL)) begin
								nxt_resp[0] = `IWR_RES_OK;
								nxt_idx     = cmd_ff[4];
								if (cmd_ff[1] == `IWR_LEN_WR_VAL) begin
									// Flag moves index past the value
									nxt_idx = cmd_ff[4] + {7'h0, cmd_ff[3][0]};
									if (cmd_ff[4] == `IWR_IDX_ACC) begin
										// Reserved bits kept clear
										nxt_acc = cmd_ff[5] & `IWR_ACC_WR_MASK;
									end
								end
							end
						end
						`IWR_CMD_PROTO: begin
							nxt_resp[0] = `IWR_RES_OK;
							nxt_acc     = `IWR_ACC_DEFAULT;
						end
						default: begin
						end
					endcase
				end
			end
			DEV_RESP: begin
				if (cs_f) begin
					// First bit must stand before first rise
					nxt_tx     = resp_ff[0];
					nxt_miso   = resp_ff[0][7];
					nxt_tx_idx = 2'h1;
				end else if (!cs_s_ff[1] && sclk_f) begin
					if (bit_ff == 3'h0) begin
						nxt_tx     = nbyte;
						nxt_miso   = nbyte[7];
						nxt_tx_idx = (tx_idx_ff == 2'h3) ? 2'h3 :
							tx_idx_ff + 2'h1;
					end else begin
						nxt_tx   = {tx_ff[6:0], 1'b0};
						nxt_miso = tx_ff[6];
					end
				end else if (cs_r) begin
					nxt_miso = 1'b0;
					// Short read leaves the answer pending
					if ({3'h0, byte_ff} >= resp_ff[1] + `IWR_LEN_HDR) begin
						nxt_state = DEV_READY;
						nxt_rdy_n = 1'b1;
					end
				end
			end
			DEV_WFE: begin
				if (wake_f && (hib_ff || wsrc_ff[`IWR_WSRC_PIN])) begin
					nxt_resp[2] = `IWR_CAUSE_PIN;
					nxt_state   = DEV_RESP;
				end else if (!hib_ff && field_r &&
					(wsrc_ff[`IWR_WSRC_FIELD] ||
					wsrc_ff[`IWR_WSRC_FIELD_ALT])) begin
					nxt_resp[2] = `IWR_CAUSE_FIELD;
					nxt_state   = DEV_RESP;
				end
				if (nxt_state == DEV_RESP) begin
					nxt_resp[0] = `IWR_RES_OK;
					nxt_resp[1] = `IWR_LEN_ONE;
					nxt_rdy_n   = 1'b0;
				end
			end
			default: begin
				nxt_state = DEV_POWERUP;
			end
		endcase
		nxt_lp    = (nxt_state == DEV_POWERUP || nxt_state == DEV_WFE);
		nxt_ready = (nxt_state == DEV_READY);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff   <= DEV_POWERUP;
			cnt_ff     <= 20'h0;
			sclk_s_ff  <= 3'h0;
			cs_s_ff    <= 3'h7;
			wake_s_ff  <= 3'h7;
			field_s_ff <= 3'h0;
			mosi_s_ff  <= 2'h0;
			rx_ff      <= 8'h00;
			tx_ff      <= 8'h00;
			bit_ff     <= 3'h0;
			byte_ff    <= 5'h0;
			tx_idx_ff  <= 2'h0;
			cmd_ff     <= '{default: 8'h00};
			resp_ff    <= '{default: 8'h00};
			wsrc_ff    <= 8'h00;
			acc_ff     <= `IWR_ACC_DEFAULT;
			idx_ff     <= 8'h00;
			hib_ff     <= 1'b0;
			miso_ff    <= 1'b0;
			rdy_n_ff   <= 1'b1;
			lp_ff      <= 1'b1;
			ready_ff   <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			sclk_s_ff  <= nxt_sclk_s;
			cs_s_ff    <= nxt_cs_s;
			wake_s_ff  <= nxt_wake_s;
			field_s_ff <= nxt_field_s;
			mosi_s_ff  <= nxt_mosi_s;
			rx_ff      <= nxt_rx;
			tx_ff      <= nxt_tx;
			bit_ff     <= nxt_bit;
			byte_ff    <= nxt_byte;
			tx_idx_ff  <= nxt_tx_idx;
			cmd_ff     <= nxt_cmd;
			resp_ff    <= nxt_resp;
			wsrc_ff    <= nxt_wsrc;
			acc_ff     <= nxt_acc;
			idx_ff     <= nxt_idx;
			hib_ff     <= nxt_hib;
			miso_ff    <= nxt_miso;
			rdy_n_ff   <= nxt_rdy_n;
			lp_ff      <= nxt_lp;
			ready_ff   <= nxt_ready;
		end
	end

	assign link.miso         = miso_ff;
	assign link.resp_rdy_n   = rdy_n_ff;
	assign low_power_out     = lp_ff;
	assign cmd_ready_out     = ready_ff;
	assign analog_config_out = acc_ff;
	assign wake_source_out   = wsrc_ff;
endmodule // iwr_device
`default_nettype wire

/* core/iwr_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iwr_defines.svh"
module iwr_host (
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	iwr_link_if.host               link,
	input  wire logic              cmd_valid_in,
	input  wire logic [127:0]      cmd_bytes_in,
	input  wire logic [4:0]        cmd_count_in,
	input  wire logic              wake_req_in,
	output logic                   busy_out,
	output logic                   resp_valid_out,
	output logic [7:0]             resp_code_out,
	output logic [7:0]             resp_len_out,
	output logic [7:0]             resp_data_out,
	output logic                   cause_valid_out
);
	import iwr_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	iwr_host_state_t state_ff, nxt_state;
	logic [3:0]   div_ff, nxt_div;       // Half period count
	logic         sclk_ff, nxt_sclk;
	logic         cs_n_ff, nxt_cs_n;
	logic         mosi_ff, nxt_mosi;
	logic [7:0]   sh_ff, nxt_sh;         // Shared in/out shifter
	logic [2:0]   bit_ff, nxt_bit;
	logic [4:0]   byte_ff, nxt_byte;
	logic [4:0]   total_ff, nxt_total;   // Bytes in this frame
	logic [127:0] buf_ff, nxt_buf;       // Command being sent
	logic [1:0]   miso_s_ff, nxt_miso_s;
	logic [1:0]   rdy_s_ff, nxt_rdy_s;
	logic [7:0]   wake_cnt_ff, nxt_wake_cnt;
	logic [7:0]   code_ff, nxt_code, len_ff, nxt_len, data_ff, nxt_data;
	logic         valid_ff, nxt_valid, busy_ff, nxt_busy;
	logic         hib_ff, nxt_hib, cause_ff, nxt_cause;

	// Force the idle command fields and the write value into legal values
	function automatic logic [127:0] fix_cmd(input logic [127:0] c);
		logic [127:0] r;
		logic         hib;
		r = c;
		if (c[7:0] == `IWR_CMD_IDLE) begin
			r[23:16] = c[23:16] | (8'h01 << `IWR_WSRC_PIN);
			hib = ({c[31:24], c[39:32]} == `IWR_ENTRY_HIB) ||
				!(c[16 + `IWR_WSRC_FIELD] || c[16 + `IWR_WSRC_FIELD_ALT]);
			{r[31:24], r[39:32]} = hib ? `IWR_ENTRY_HIB :
				`IWR_ENTRY_SLEEP;
			{r[47:40], r[55:48]} = hib ? `IWR_WAKE_HIB :
				`IWR_WAKE_SLEEP;
			{r[63:56], r[71:64]} = `IWR_EXIT_CTRL;
		end
		if (c[7:0] == `IWR_CMD_WRITE && c[15:8] == `IWR_LEN_WR_VAL) begin
			r[47:40] = c[47:40] & `IWR_ACC_WR_MASK;
		end
		return r;
	endfunction

	logic [7:0] inb;
	logic [7:0] next_out;
	assign inb      = {sh_ff[6:0], miso_s_ff[1]};
	assign next_out = buf_ff[{byte_ff[3:0], 3'h0} +: 8];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state    = state_ff;
		nxt_div      = div_ff;
		nxt_sclk     = sclk_ff;
		nxt_cs_n     = cs_n_ff;
		nxt_mosi     = mosi_ff;
		nxt_sh       = sh_ff;
		nxt_bit      = bit_ff;
		nxt_byte     = byte_ff;
		nxt_total    = total_ff;
		nxt_buf      = buf_ff;
		nxt_miso_s   = {miso_s_ff[0], link.miso};
		nxt_rdy_s    = {rdy_s_ff[0], link.resp_rdy_n};
		nxt_wake_cnt = wake_cnt_ff;
		nxt_code     = code_ff;
		nxt_len      = len_ff;
		nxt_data     = data_ff;
		nxt_valid    = 1'b0;
		nxt_busy     = busy_ff;
		nxt_hib      = hib_ff;
		nxt_cause    = cause_ff;
		// Wake pulse runs beside any transfer
		if (wake_cnt_ff != 8'h00) begin
			nxt_wake_cnt = wake_cnt_ff - 8'h01;
		end else if (wake_req_in) begin
			nxt_wake_cnt = `IWR_WAKE_LOW;
		end
		// Serial bit engine, mode 0
		if (state_ff == HST_SEND || state_ff == HST_READ) begin
			nxt_div = div_ff + 4'h1;
			if (div_ff == `IWR_HALF_PER - 4'h1) begin
				nxt_div  = 4'h0;
				nxt_sclk = ~sclk_ff;
				if (!sclk_ff) begin
					// Rising edge: sample and count
					nxt_sh  = inb;
					nxt_bit = bit_ff + 3'h1;
					if (bit_ff == 3'h7) begin
						nxt_byte = byte_ff + 5'h1;
						if (state_ff == HST_READ) begin
							case (byte_ff)
								5'h0: nxt_code = inb;
								5'h1: begin
									nxt_len   = inb;
									nxt_total = (inb == 8'h00) ? 5'h2 : 5'h3;
								end
								5'h2: nxt_data = inb;
								default: begin
								end
							endcase
						end
					end
				end else if (bit_ff != 3'h0) begin
					nxt_mosi = sh_ff[7];
				end else if (byte_ff == total_ff) begin
					// Frame over after last falling edge
					nxt_cs_n  = 1'b1;
					nxt_mosi  = 1'b0;
					nxt_state = (state_ff == HST_SEND) ? HST_WAIT :
						HST_DONE;
				end else begin
					nxt_sh   = (state_ff == HST_SEND) ? next_out : 8'h00;
					nxt_mosi = (state_ff == HST_SEND) ? next_out[7] : 1'b0;
				end
			end
		end
		case (state_ff)
			HST_IDLE: begin
				if (cmd_valid_in && cmd_count_in >= 5'h2) begin
					nxt_buf   = fix_cmd(cmd_bytes_in);
					nxt_sh    = nxt_buf[7:0];
					nxt_mosi  = nxt_buf[7];
					nxt_cs_n  = 1'b0;
					nxt_div   = 4'h0;
					nxt_bit   = 3'h0;
					nxt_byte  = 5'h0;
					nxt_total = cmd_count_in;
					nxt_busy  = 1'b1;
					nxt_hib   = nxt_buf[7:0] == `IWR_CMD_IDLE &&
						{nxt_buf[31:24], nxt_buf[39:32]} == `IWR_ENTRY_HIB;
					nxt_state = HST_SEND;
				end
			end
			HST_SEND: begin
			end
			HST_WAIT: begin
				// No new command until this answer is read
				if (!rdy_s_ff[1]) begin
					nxt_cs_n  = 1'b0;
					nxt_sh    = 8'h00;
					nxt_mosi  = 1'b0;
					nxt_div   = 4'h0;
					nxt_bit   = 3'h0;
					nxt_byte  = 5'h0;
					nxt_total = 5'h2;
					nxt_state = HST_READ;
				end
			end
			HST_READ: begin
			end
			HST_DONE: begin
				nxt_valid = 1'b1;
				nxt_cause = !hib_ff;
				nxt_busy  = 1'b0;
				nxt_state = HST_IDLE;
			end
			default: begin
				nxt_state = HST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff    <= HST_IDLE;
			div_ff      <= 4'h0;
			sclk_ff     <= 1'b0;
			cs_n_ff     <= 1'b1;
			mosi_ff     <= 1'b0;
			sh_ff       <= 8'h00;
			bit_ff      <= 3'h0;
			byte_ff     <= 5'h0;
			total_ff    <= 5'h0;
			buf_ff      <= 128'h0;
			miso_s_ff   <= 2'h0;
			rdy_s_ff    <= 2'h3;
			wake_cnt_ff <= 8'h00;
			code_ff     <= 8'h00;
			len_ff      <= 8'h00;
			data_ff     <= 8'h00;
			valid_ff    <= 1'b0;
			busy_ff     <= 1'b0;
			hib_ff      <= 1'b0;
			cause_ff    <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			div_ff      <= nxt_div;
			sclk_ff     <= nxt_sclk;
			cs_n_ff     <= nxt_cs_n;
			mosi_ff     <= nxt_mosi;
			sh_ff       <= nxt_sh;
			bit_ff      <= nxt_bit;
			byte_ff     <= nxt_byte;
			total_ff    <= nxt_total;
			buf_ff      <= nxt_buf;
			miso_s_ff   <= nxt_miso_s;
			rdy_s_ff    <= nxt_rdy_s;
			wake_cnt_ff <= nxt_wake_cnt;
			code_ff     <= nxt_code;
			len_ff      <= nxt_len;
			data_ff     <= nxt_data;
			valid_ff    <= nxt_valid;
			busy_ff     <= nxt_busy;
			hib_ff      <= nxt_hib;
			cause_ff    <= nxt_cause;
		end
	end

	assign link.sclk       = sclk_ff;
	assign link.cs_n       = cs_n_ff;
	assign link.mosi       = mosi_ff;
	assign link.wake_n     = (wake_cnt_ff == 8'h00);
	assign busy_out        = busy_ff;
	assign resp_valid_out  = valid_ff;
	assign resp_code_out   = code_ff;
	assign resp_len_out    = len_ff;
	assign resp_data_out   = data_ff;
	assign cause_valid_out = cause_ff;
endmodule // iwr_host
`default_nettype wire

/* bench/iwr_link_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Link protocol checker
// ------------------------------
module iwr_link_checker (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic wake_n,
	input wire logic resp_rdy_n
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);
	// One high phase of the serial clock
	sequence s_half_high;
		sclk[*8] ##1 !sclk;
	endsequence
	// Low span that the device can sample
	sequence s_wake_low;
		(!wake_n)[*8];
	endsequence
	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock moved outside a frame");
	a_sclk_half_high: assert property ($rose(sclk) |-> s_half_high)
		else $error("serial clock high phase wrong");
	a_cs_setup_gap: assert property ($fell(cs_n) |-> (!sclk)[*8])
		else $error("serial clock too soon after select");
	a_mosi_steady_high: assert property (sclk |-> $stable(mosi))
		else $error("host data moved while clock high");
	a_wake_min_low: assert property ($fell(wake_n) |-> s_wake_low)
		else $error("wake pulse too short");
	a_wake_pulse_end: assert property ($fell(wake_n) |-> ##[28:36] wake_n)
		else $error("wake pulse never ended");
	a_resp_between_frames: assert property ($fell(resp_rdy_n) |-> cs_n)
		else $error("answer flagged inside a frame");
	a_resp_holds_frame: assert property (!resp_rdy_n && !cs_n |=> !resp_rdy_n)
		else $error("pending answer dropped mid frame");
endmodule // iwr_link_checker
`default_nettype wire

/* bench/idle_wake_and_analog_reg_cmds_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Both ends joined, host side driven
// ------------------------------
module idle_wake_and_analog_reg_cmds_bench;
	logic         clock_in = 1'b0;        // 100 MHz clock
	logic         rst_in = 1'b1;          // Async reset
	logic         field_detect_in = 1'b0; // RF field present
	logic         cmd_valid_in = 1'b0;    // Host command strobe
	logic [127:0] cmd_bytes_in = '0;      // Frame bytes
	logic [4:0]   cmd_count_in = 5'h02;   // Bytes to send
	logic         wake_req_in = 1'b0;     // Wake pulse request
	logic         low_power_out, cmd_ready_out, busy_out;
	logic         resp_valid_out, cause_valid_out;
	logic [7:0]   analog_config_out, wake_source_out;
	logic [7:0]   resp_code_out, resp_len_out, resp_data_out;
	logic [7:0]   q[$];                   // Next command frame
	logic [7:0]   acc;                    // Model of the config
	int           err_total = 0;
	int           comparisons = 0;
	iwr_link_if lnk ();
	iwr_device #(.STARTUP_CYCLES(50)) iwr_device_inst (.clock_in(clock_in),
		.rst_in(rst_in), .link(lnk), .field_detect_in(field_detect_in),
		.low_power_out(low_power_out), .cmd_ready_out(cmd_ready_out),
		.analog_config_out(analog_config_out),
		.wake_source_out(wake_source_out));
	iwr_host iwr_host_inst (.clock_in(clock_in), .rst_in(rst_in), .link(lnk),
		.cmd_valid_in(cmd_valid_in), .cmd_bytes_in(cmd_bytes_in),
		.cmd_count_in(cmd_count_in), .wake_req_in(wake_req_in),
		.busy_out(busy_out), .resp_valid_out(resp_valid_out),
		.resp_code_out(resp_code_out), .resp_len_out(resp_len_out),
		.resp_data_out(resp_data_out), .cause_valid_out(cause_valid_out));
	iwr_link_checker iwr_link_checker_inst (.clock_in(clock_in),
		.rst_in(rst_in), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
		.miso(lnk.miso), .wake_n(lnk.wake_n), .resp_rdy_n(lnk.resp_rdy_n));
	// Free running clock
	always #5 clock_in = ~clock_in;
	// Compare one value and count it
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bounded wait for a level; a hang counts as a mismatch
	task automatic await(ref logic s, input int lim);
		int n;
		for (n = 0; n < lim && s !== 1'b1; n++) @(negedge clock_in);
		if (n == lim) err_total++;
	endtask
	// Hand the frame in q to the host, held until it is taken
	task automatic issue();
		@(negedge clock_in);
		cmd_bytes_in = '0;
		foreach (q[i]) cmd_bytes_in[8*i +: 8] = q[i];
		cmd_count_in = 5'(q.size());
		cmd_valid_in = 1'b1;
		await(busy_out, 50);
		cmd_valid_in = 1'b0;
	endtask
	// Wait for the answer; data only exists when length is one
	task automatic expect_resp(string nm, logic [7:0] c, l, d);
		await(resp_valid_out, 20000);
		chk("result code", c, resp_code_out);
		chk("length", l, resp_len_out);
		if (l == 8'h01) chk("data", d, resp_data_out);
		$display("test %s done", nm);
	endtask
	task automatic run(string nm, logic [7:0] c, l, d);
		issue();
		expect_resp(nm, c, l, d);
	endtask
	// Watchdog: all tests need about a fifth of this
	initial begin
		#1_000_000;
		err_total++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'hEC5CA211));
		repeat (12) @(posedge clock_in);
		@(negedge clock_in);
		rst_in = 1'b0;
		chk("config reset", 8'h27, analog_config_out);
		wake_req_in = 1'b1;
		@(negedge clock_in);
		wake_req_in = 1'b0;
		await(cmd_ready_out, 500);
		q = '{8'h08, 8'h03, 8'h62, 8'h01, 8'h00};
		run("rd_wake", 8'h00, 8'h01, 8'h00);
		q = '{8'h08, 8'h02, 8'h62, 8'h01};
		run("bad_len", 8'h82, 8'h00, 8'h00);
		q = '{8'h08, 8'h03, 8'h63, 8'h01, 8'h00};
		run("bad_addr", 8'h82, 8'h00, 8'h00);
		q = '{8'h09, 8'h03, 8'h68, 8'h00, 8'h04};
		run("set_idx", 8'h00, 8'h00, 8'h00);
		q = '{8'h08, 8'h03, 8'h69, 8'h01, 8'h00};
		run("rd_default", 8'h00, 8'h01, 8'h27);
		// Random values; the two reserved bits must come back clear
		repeat (3) begin
			acc = 8'($urandom);
			q = '{8'h09, 8'h04, 8'h68, 8'h01, 8'h04, acc};
			run("wr_val", 8'h00, 8'h00, 8'h00);
			acc = acc & 8'h3F;
			chk("config", acc, analog_config_out);
			q = '{8'h09, 8'h03, 8'h68, 8'h00, 8'h04};
			run("re_idx", 8'h00, 8'h00, 8'h00);
			q = '{8'h08, 8'h03, 8'h69, 8'h01, 8'h00};
			run("rd_val", 8'h00, 8'h01, acc);
		end
		q = '{8'h02, 8'h02, 8'h12, 8'h08};
		run("proto", 8'h00, 8'h00, 8'h00);
		chk("config default", 8'h27, analog_config_out);
		// Sleep with field and pin both enabled
		q = '{8'h07, 8'h0E, 8'h0A, 8'h01, 8'h42, 8'h38, 8'h00, 8'h18,
			8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		issue();
		await(low_power_out, 5000);
		chk("sources", 8'h0A, wake_source_out);
		field_detect_in = 1'b1;
		expect_resp("field_wake", 8'h00, 8'h01, 8'h04);
		chk("cause valid", 8'h01, 8'(cause_valid_out));
		field_detect_in = 1'b0;
		// Hibernate: the field must not end it, only the pin
		q = '{8'h07, 8'h0E, 8'h08, 8'h04, 8'h00, 8'h04, 8'h00, 8'h18,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		issue();
		await(low_power_out, 5000);
		field_detect_in = 1'b1;
		repeat (300) @(negedge clock_in);
		chk("asleep", 8'h01, 8'(low_power_out));
		field_detect_in = 1'b0;
		wake_req_in = 1'b1;
		@(negedge clock_in);
		wake_req_in = 1'b0;
		expect_resp("pin_wake", 8'h00, 8'h01, 8'h08);
		chk("cause valid", 8'h00, 8'(cause_valid_out));
		tally_and_finish();
	end
endmodule // idle_wake_and_analog_reg_cmds_bench
`default_nettype wire
